// File: verilog/rhs_consts.svh
// Purpose: constants of the reader host serial command port
// Assumes: included by the package, the port and the bench
// Notes: offsets are 6-bit register addresses
`ifndef RHS_CONSTS_SVH
`define RHS_CONSTS_SVH
`define RHS_OFS_IRQ_STATUS 6'h38
`define RHS_OFS_TX_LEN_FIRST 6'h3d
`define RHS_OFS_TX_LEN_SECOND 6'h3e
`define RHS_OFS_FIFO 6'h3f
`define RHS_OFS_CFG_BASE 6'h00
`define RHS_CFG_COUNT 8
`define RHS_IRQ_CMD_BIT 7
`define RHS_MODE_WRITE 2'h0
`define RHS_MODE_READ 2'h1
`define RHS_MODE_CMD 2'h2
`define RHS_CMD_IDLE 6'h00
`define RHS_CMD_DIRECT 6'h01
`define RHS_CMD_SOFT_INIT 6'h03
`define RHS_CMD_HOP_MAIN 6'h04
`define RHS_CMD_HOP_AUX 6'h05
`define RHS_CMD_ADC 6'h07
`define RHS_CMD_RXCAL 6'h08
`define RHS_CMD_RXCAL_DEC 6'h09
`define RHS_CMD_RXCAL_INC 6'h0a
`define RHS_CMD_TX_CRC 6'h10
`define RHS_CMD_TX_HDR 6'h11
`define RHS_CMD_TX_NOCRC 6'h12
`define RHS_CMD_BLOCK_RX 6'h16
`define RHS_CMD_ENABLE_RX 6'h17
`define RHS_CMD_QUERY 6'h18
`define RHS_CMD_QUERY_LAST 6'h1f
`define RHS_CMD_SUPPLY_AUTO 6'h22
`define RHS_CMD_VCO_AUTO 6'h24
`define RHS_CMD_LAST 6'h2b
`define RHS_LONG_CMD_NS 2000
`define RHS_LONG_CMD_CYC ((`RHS_LONG_CMD_NS + 9) / 10)
`define RHS_RX_WAIT_NS 1000
`define RHS_RX_WAIT_CYC ((`RHS_RX_WAIT_NS + 9) / 10)
`define RHS_CFG_RESET 8'h00
`endif

// File: verilog/rhs_pkg.sv
// Purpose: types of the reader host serial command port
// Assumes: rhs_consts.svh
// Notes: none
`include "rhs_consts.svh"
package rhs_pkg;
   typedef enum logic [3:0]
   {
      RHS_ST_MODE = 4'b0001,
      RHS_ST_ADDR = 4'b0010,
      RHS_ST_DATA = 4'b0100,
      RHS_ST_HOLD = 4'b1000
   } rhs_state_e;

   typedef struct packed
   {
      logic tx_start;
      logic tx_append_crc;
      logic rx_expect_header;
      logic query_start;
   } rhs_tx_ctrl_s;

   typedef struct packed
   {
      logic rx_blocked;
      logic synth_aux;
      logic adc_start;
      logic long_busy;
   } rhs_core_s;
endpackage : rhs_pkg

// File: verilog/rhs_sync_edge.sv
// Purpose: synchronise serial pins and find clock edges
// Assumes: pins are asynchronous to clk_sys
// Notes: first flop read only by second flop
`timescale 1ns/1ns
`default_nettype none
module rhs_sync_edge
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sclk_pin,
   input wire logic mosi_pin,
   input wire logic sel_n_pin,
   output logic sclk_rise,
   output logic sclk_fall,
   output logic mosi_s,
   output logic sel_n_s
);
   logic [2:0] meta;
   logic [2:0] stable;
   logic sclk_last;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         // Idle levels: select high, clock low, so no false edge after reset
         meta <= 3'h6;
         stable <= 3'h6;
         sclk_last <= 1'b0;
      end
      else
      begin
         meta <= {sel_n_pin, mosi_pin, sclk_pin};
         stable <= meta;
         sclk_last <= stable[0];
      end
   end

   assign sclk_rise = stable[0] & ~sclk_last;
   assign sclk_fall = ~stable[0] & sclk_last;
   assign mosi_s = stable[1];
   assign sel_n_s = stable[2];
endmodule : rhs_sync_edge
`default_nettype wire

// File: verilog/rhs_port.sv
// Purpose: host serial command port with register access and direct commands
// Assumes: sclk well below clk_sys/4, pins asynchronous
// Notes: serial pins pass two flops; outputs registered
// Overview of operation
// - Partial data byte at deselect is dropped
// - Writes to missing or read-only addresses ignored
// - Write frame: mode, address, data bytes
// - Input bit captured on serial clock fall
// - Read output changes on serial clock rise
// - Unimplemented read address returns all zeros
// - Mode one-zero is direct command, six-bit id
// - Query takes two FIFO parameter bytes
// - Command starts at last falling edge
// - Finished command sets done flag and interrupt
// - Four codes run long, others immediate
// - Soft init resets config, aborts functions
// - Hop commands select main or auxiliary set
// - Transmit starts on first FIFO byte, CRC
// - Header-bit variant and no-CRC variant
// - Block rx disables decoder and framer
// - Rx resumes after transmit wait or enable
// - ADC trigger starts eight-bit conversion
// - Top two bits select write, read, command
// - All bytes travel most significant bit first
// - Output driven only while shifting read data
// - Address increments after each data byte, except at the FIFO address, which holds
`timescale 1ns/1ns
`default_nettype none
`include "rhs_consts.svh"
module rhs_port
   import rhs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic irq_status_clear,
   input wire logic tx_done,
   output logic miso_out,
   output logic miso_oe,
   output logic irq,
   output logic [7:0] irq_status_main,
   output rhs_tx_ctrl_s tx_ctrl,
   output rhs_core_s core,
   output logic [7:0] fifo_wdata,
   output logic fifo_wvalid,
   output logic [15:0] tx_length
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   logic sclk_rise;
   logic sclk_fall;
   logic mosi_s;
   logic sel_n_s;

   rhs_sync_edge u_sync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .sclk_pin(sclk),
      .mosi_pin(mosi),
      .sel_n_pin(sel_n),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .mosi_s(mosi_s),
      .sel_n_s(sel_n_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame state
   rhs_state_e state;
   logic [2:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] shift_out;
   logic [1:0] op_select;
   logic [5:0] register_address_bits;
   logic [7:0] cfg [`RHS_CFG_COUNT];
   logic [7:0] tx_length_first;
   logic [7:0] tx_length_second;
   logic [7:0] fifo_last;
   logic tx_armed;
   logic [7:0] irq_stat;
   logic [15:0] long_cnt;
   logic [15:0] wait_cnt;
   logic rx_wait;

   function automatic logic is_cfg(input logic [5:0] a);
      is_cfg = a < 6'(`RHS_CFG_COUNT);
   endfunction : is_cfg

   function automatic logic is_known_cmd(input logic [5:0] c);
      unique case (c)
         `RHS_CMD_IDLE, `RHS_CMD_DIRECT, `RHS_CMD_SOFT_INIT, `RHS_CMD_HOP_MAIN,
         `RHS_CMD_HOP_AUX, `RHS_CMD_ADC, `RHS_CMD_RXCAL, `RHS_CMD_RXCAL_DEC,
         `RHS_CMD_RXCAL_INC, `RHS_CMD_TX_CRC, `RHS_CMD_TX_HDR, `RHS_CMD_TX_NOCRC,
         `RHS_CMD_BLOCK_RX, `RHS_CMD_ENABLE_RX, 6'h18, 6'h19, 6'h1a, 6'h1b,
         6'h1c, 6'h1d, 6'h1f, `RHS_CMD_SUPPLY_AUTO, 6'h23, `RHS_CMD_VCO_AUTO,
         6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, `RHS_CMD_LAST:
            is_known_cmd = 1'b1;
         default:
            is_known_cmd = 1'b0;
      endcase
   endfunction : is_known_cmd

   function automatic logic is_long_cmd(input logic [5:0] c);
      is_long_cmd = (c == `RHS_CMD_ADC) || (c == `RHS_CMD_RXCAL) ||
         (c == `RHS_CMD_SUPPLY_AUTO) || (c == `RHS_CMD_VCO_AUTO);
   endfunction : is_long_cmd

   // The FIFO port keeps its address so a burst can stream payload into it
   function automatic logic [5:0] next_addr(input logic [5:0] a);
      next_addr = (a == `RHS_OFS_FIFO) ? a : a + 6'h01;
   endfunction : next_addr

   // Byte complete on the eighth falling edge
   wire [7:0] next_byte = {shift_in[6:0], mosi_s};
   wire byte_done = sclk_fall && !sel_n_s && (bit_cnt == 3'h7);
   wire first_byte = byte_done && (state == RHS_ST_MODE);
   wire [1:0] new_op = next_byte[7:6];
   wire [5:0] new_id = next_byte[5:0];
   wire cmd_fire = first_byte && (new_op == `RHS_MODE_CMD);
   wire cmd_known = cmd_fire && is_known_cmd(new_id);
   wire cmd_long = cmd_known && is_long_cmd(new_id);
   wire cmd_quick = cmd_known && !cmd_long;
   wire soft_init = cmd_known && (new_id == `RHS_CMD_SOFT_INIT);
   wire is_tx_cmd = (new_id == `RHS_CMD_TX_CRC) || (new_id == `RHS_CMD_TX_HDR) ||
      (new_id == `RHS_CMD_TX_NOCRC);
   wire is_query = (new_id >= `RHS_CMD_QUERY) && (new_id <= `RHS_CMD_QUERY_LAST);
   wire long_done = core.long_busy && (long_cnt == 16'h0001);
   wire data_byte = byte_done && (state == RHS_ST_DATA);
   wire wr_byte = data_byte && (op_select == `RHS_MODE_WRITE);
   wire wr_cfg = wr_byte && is_cfg(register_address_bits);
   wire wr_len1 = wr_byte && (register_address_bits == `RHS_OFS_TX_LEN_FIRST);
   wire wr_len2 = wr_byte && (register_address_bits == `RHS_OFS_TX_LEN_SECOND);
   wire wr_fifo = wr_byte && (register_address_bits == `RHS_OFS_FIFO);
   wire reading = (op_select == `RHS_MODE_READ) && (state == RHS_ST_DATA);

   // Read mux; anything not mapped reads as zero
   function automatic logic [7:0] rd_value(input logic [5:0] a);
      if (is_cfg(a))
         rd_value = cfg[a[2:0]];
      else if (a == `RHS_OFS_IRQ_STATUS)
         rd_value = irq_stat;
      else if (a == `RHS_OFS_TX_LEN_FIRST)
         rd_value = tx_length_first;
      else if (a == `RHS_OFS_TX_LEN_SECOND)
         rd_value = tx_length_second;
      else if (a == `RHS_OFS_FIFO)
         rd_value = fifo_last;
      else
         rd_value = 8'h00;
   endfunction : rd_value

   ////////////////////////////////////////////////////////////////////////////
   // Serial framing
   always_ff @(posedge clk_sys)
   begin
      if (reset || sel_n_s)
      begin
         state <= RHS_ST_MODE;
         bit_cnt <= 3'h0;
         shift_in <= 8'h00;
         op_select <= 2'h0;
      end
      else if (sclk_fall)
      begin
         shift_in <= next_byte;
         bit_cnt <= bit_cnt + 3'h1;
         if (first_byte)
         begin
            op_select <= new_op;
            // All direct commands, long ones too, may be chained with another access
            state <= (new_op == `RHS_MODE_CMD) ? RHS_ST_MODE :
               (new_op == 2'h3) ? RHS_ST_HOLD : RHS_ST_DATA;
         end
      end
   end

   // Address is taken from the first byte, then advances per data byte except at the FIFO
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         register_address_bits <= 6'h00;
      else if (first_byte)
         register_address_bits <= new_id;
      else if (data_byte)
         register_address_bits <= next_addr(register_address_bits);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read shifter: load before the first rise of each data byte
   always_ff @(posedge clk_sys)
   begin
      if (reset || sel_n_s)
      begin
         shift_out <= 8'h00;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end
      else if (first_byte && new_op == `RHS_MODE_READ)
      begin
         shift_out <= rd_value(new_id);
         miso_oe <= 1'b1;
      end
      else if (reading && sclk_rise)
      begin
         miso_out <= shift_out[7];
         shift_out <= {shift_out[6:0], 1'b0};
      end
      else if (reading && data_byte)
         shift_out <= rd_value(next_addr(register_address_bits));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   always_ff @(posedge clk_sys)
   begin
      if (reset || soft_init)
      begin
         for (int i = 0; i < `RHS_CFG_COUNT; i++)
            cfg[i] <= `RHS_CFG_RESET;
         tx_length_first <= 8'h00;
         tx_length_second <= 8'h00;
      end
      else
      begin
         if (wr_cfg)
            cfg[register_address_bits[2:0]] <= next_byte;
         if (wr_len1)
            tx_length_first <= next_byte;
         if (wr_len2)
            tx_length_second <= next_byte;
         // Status and unmapped writes are dropped here
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         fifo_last <= 8'h00;
         fifo_wdata <= 8'h00;
         fifo_wvalid <= 1'b0;
      end
      else
      begin
         fifo_wvalid <= wr_fifo;
         if (wr_fifo)
         begin
            fifo_last <= next_byte;
            fifo_wdata <= next_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direct command actions
   always_ff @(posedge clk_sys)
   begin
      if (reset || soft_init)
      begin
         tx_armed <= 1'b0;
         tx_ctrl <= '0;
         core <= '0;
         long_cnt <= 16'h0000;
         rx_wait <= 1'b0;
         wait_cnt <= 16'h0000;
      end
      else
      begin
         tx_ctrl.tx_start <= 1'b0;
         tx_ctrl.query_start <= 1'b0;
         core.adc_start <= 1'b0;
         if (cmd_known && is_tx_cmd)
         begin
            tx_armed <= 1'b1;
            tx_ctrl.tx_append_crc <= (new_id != `RHS_CMD_TX_NOCRC);
            tx_ctrl.rx_expect_header <= (new_id == `RHS_CMD_TX_HDR);
         end
         else if (tx_armed && wr_fifo)
         begin
            tx_armed <= 1'b0;
            tx_ctrl.tx_start <= 1'b1;
         end
         if (cmd_known && is_query)
            tx_ctrl.query_start <= 1'b1;
         if (cmd_known && new_id == `RHS_CMD_HOP_MAIN)
            core.synth_aux <= 1'b0;
         if (cmd_known && new_id == `RHS_CMD_HOP_AUX)
            core.synth_aux <= 1'b1;
         if (cmd_known && new_id == `RHS_CMD_ADC)
            core.adc_start <= 1'b1;
         if (cmd_long)
         begin
            core.long_busy <= 1'b1;
            long_cnt <= 16'(`RHS_LONG_CMD_CYC);
         end
         else if (long_done)
            core.long_busy <= 1'b0;
         else if (core.long_busy)
            long_cnt <= long_cnt - 16'h0001;
         // Rx block and recovery
         if (cmd_known && new_id == `RHS_CMD_BLOCK_RX)
            core.rx_blocked <= 1'b1;
         else if (cmd_known && new_id == `RHS_CMD_ENABLE_RX)
         begin
            core.rx_blocked <= 1'b0;
            rx_wait <= 1'b0;
         end
         else if (tx_done)
         begin
            rx_wait <= 1'b1;
            wait_cnt <= 16'(`RHS_RX_WAIT_CYC);
         end
         else if (rx_wait && wait_cnt == 16'h0001)
         begin
            rx_wait <= 1'b0;
            core.rx_blocked <= 1'b0;
         end
         else if (rx_wait)
            wait_cnt <= wait_cnt - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command-done flag: set wins over clear
   wire cmd_finished = cmd_quick || long_done;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         irq_stat <= 8'h00;
         irq <= 1'b0;
      end
      else
      begin
         if (cmd_finished)
            irq_stat[`RHS_IRQ_CMD_BIT] <= 1'b1;
         else if (irq_status_clear)
            irq_stat[`RHS_IRQ_CMD_BIT] <= 1'b0;
         irq <= cmd_finished || (irq_stat[`RHS_IRQ_CMD_BIT] && !irq_status_clear);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         irq_status_main <= 8'h00;
         tx_length <= 16'h0000;
      end
      else
      begin
         irq_status_main <= irq_stat;
         tx_length <= {tx_length_first, tx_length_second};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   partial_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sel_n_s && state == RHS_ST_DATA) |=> $stable(tx_length_first) && $stable(cfg[0]))
      else $error("partial write changed a register");
   ro_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_byte && register_address_bits == `RHS_OFS_IRQ_STATUS && !cmd_finished
      && !irq_status_clear) |=> $stable(irq_stat))
      else $error("write to status stored data");
   sample_fall_a: assert property (@(posedge clk_sys) disable iff (reset || sel_n_s)
      !sclk_fall |=> $stable(bit_cnt))
      else $error("bit counted without falling edge");
   shift_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(miso_out) && !$past(sel_n_s) |-> $past(sclk_rise))
      else $error("read bit changed off a rising edge");
   zero_read_a: assert property (@(posedge clk_sys) disable iff (reset)
      (first_byte && new_op == `RHS_MODE_READ && !is_cfg(new_id) &&
      new_id < `RHS_OFS_IRQ_STATUS) |=> shift_out == 8'h00)
      else $error("unmapped read not zero");
   cmd_done_a: assert property (@(posedge clk_sys) disable iff (reset)
      cmd_quick |=> irq && irq_stat[`RHS_IRQ_CMD_BIT])
      else $error("command done not flagged");
   long_cmd_a: assert property (@(posedge clk_sys) disable iff (reset || soft_init)
      cmd_long |=> core.long_busy ##0 !irq_stat[`RHS_IRQ_CMD_BIT] || $past(irq_stat[7]))
      else $error("long command finished at once");
   hop_aux_a: assert property (@(posedge clk_sys) disable iff (reset)
      (cmd_known && new_id == `RHS_CMD_HOP_AUX) |=> core.synth_aux)
      else $error("hop to auxiliary ignored");
   block_rx_a: assert property (@(posedge clk_sys) disable iff (reset)
      (cmd_known && new_id == `RHS_CMD_BLOCK_RX) |=> core.rx_blocked)
      else $error("block rx ignored");
   miso_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      sel_n_s |=> !miso_oe)
      else $error("output driven while deselected");
   addr_inc_a: assert property (@(posedge clk_sys) disable iff (reset)
      (data_byte && register_address_bits != `RHS_OFS_FIFO) |=>
      register_address_bits == $past(register_address_bits) + 6'h01)
      else $error("address did not advance");
   fifo_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
      (data_byte && register_address_bits == `RHS_OFS_FIFO) |=>
      register_address_bits == `RHS_OFS_FIFO)
      else $error("fifo address moved");
   unknown_cmd_a: assert property (@(posedge clk_sys) disable iff (reset)
      (cmd_fire && !cmd_known && !long_done) |=> !$rose(irq_stat[`RHS_IRQ_CMD_BIT]))
      else $error("unknown command flagged done");

   write_cov_c: cover property (@(posedge clk_sys) wr_len1 ##[1:200] wr_len2);
   read_cov_c: cover property (@(posedge clk_sys) reading && data_byte);
   tx_cov_c: cover property (@(posedge clk_sys) tx_ctrl.tx_start);
   long_cov_c: cover property (@(posedge clk_sys) long_done);
endmodule : rhs_port
`default_nettype wire

// File: tb/rhs_host_model.sv
// Purpose: host-side serial master that drives frames into the port
// Assumes: 16 clk_sys per serial bit (160 ns), serial clock idles low
// Notes: data line inverted on release so a stale bit never looks valid
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
module rhs_host_model
(
   input wire logic clk_sys,
   input wire logic miso_out,
   input wire logic miso_oe,
   output logic sclk,
   output logic mosi,
   output logic sel_n,
   output logic [7:0] rx_byte,
   output logic rx_driven
);
   initial
   begin
      sclk = 1'b0;
      mosi = 1'b0;
      sel_n = 1'b1;
      rx_byte = 8'h00;
      rx_driven = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // Long lead-out covers the hold time a command byte needs
   task automatic frame(input logic open);
      repeat (8) @(negedge clk_sys);
      sel_n = ~open;
      if (!open)
         mosi = ~mosi;
      repeat (4) @(negedge clk_sys);
   endtask : frame
   // Bit set well before the fall; read data taken at the fall
   task automatic xfer(input logic [7:0] tx, input int nbits);
      rx_driven = 1'b1;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         mosi = tx[i];
         repeat (4) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (8) @(negedge clk_sys);
         sclk = 1'b0;
         // Undriven line reads as the inverse so a stale bit cannot pass
         rx_byte[i] = miso_oe ? miso_out : ~miso_out;
         rx_driven = rx_driven & miso_oe;
         repeat (4) @(negedge clk_sys);
      end
   endtask : xfer
endmodule : rhs_host_model
`default_nettype wire

// File: tb/test_reader_host_spi_command_port.sv
// Purpose: self-checking bench of the host serial command port
// Assumes: host model paces the serial clock at 160 ns
// Notes: command rows cover the known codes other than soft init, the three transmit codes and 0x18; long ones are waited out
`timescale 1ns/1ns
`default_nettype none
`include "rhs_consts.svh"
module test_reader_host_spi_command_port
   import rhs_pkg::*;
;
   typedef struct packed
   {
      logic [7:0] code;
      logic long_run;
      logic aux;
      logic blocked;
   } rhs_row_s;
   localparam rhs_row_s cmd_rows [28] = '{
      '{8'h80, 1'b0, 1'b0, 1'b0}, '{8'h81, 1'b0, 1'b0, 1'b0}, '{8'h85, 1'b0, 1'b1, 1'b0},
      '{8'h84, 1'b0, 1'b0, 1'b0}, '{8'h85, 1'b0, 1'b1, 1'b0}, '{8'h96, 1'b0, 1'b1, 1'b1},
      '{8'h97, 1'b0, 1'b1, 1'b0}, '{8'h96, 1'b0, 1'b1, 1'b1}, '{8'h89, 1'b0, 1'b1, 1'b1},
      '{8'h8a, 1'b0, 1'b1, 1'b1}, '{8'ha3, 1'b0, 1'b1, 1'b1}, '{8'ha5, 1'b0, 1'b1, 1'b1},
      '{8'ha6, 1'b0, 1'b1, 1'b1}, '{8'ha7, 1'b0, 1'b1, 1'b1}, '{8'ha8, 1'b0, 1'b1, 1'b1},
      '{8'ha9, 1'b0, 1'b1, 1'b1}, '{8'haa, 1'b0, 1'b1, 1'b1}, '{8'hab, 1'b0, 1'b1, 1'b1},
      '{8'h99, 1'b0, 1'b1, 1'b1}, '{8'h9d, 1'b0, 1'b1, 1'b1}, '{8'h9f, 1'b0, 1'b1, 1'b1},
      '{8'h9a, 1'b0, 1'b1, 1'b1}, '{8'h9b, 1'b0, 1'b1, 1'b1}, '{8'h9c, 1'b0, 1'b1, 1'b1},
      '{8'h87, 1'b1, 1'b1, 1'b1}, '{8'h88, 1'b1, 1'b1, 1'b1}, '{8'ha2, 1'b1, 1'b1, 1'b1},
      '{8'ha4, 1'b1, 1'b1, 1'b1}};
   logic clk_sys, reset, sclk, mosi, sel_n, irq_status_clear, tx_done;
   logic miso_out, miso_oe, irq, fifo_wvalid, rx_driven;
   logic [7:0] irq_status_main, fifo_wdata, rx_byte;
   logic [7:0] got [8];
   logic [15:0] tx_length;
   rhs_tx_ctrl_s tx_ctrl;
   rhs_core_s core;
   int n_fail, n_checks, n_tx, n_query, n_adc, n_fifo, cyc;
   ////////////////////////////////////////////////////////////////////
   rhs_port u_rhs_port
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .sclk(sclk),
      .mosi(mosi),
      .sel_n(sel_n),
      .irq_status_clear(irq_status_clear),
      .tx_done(tx_done),
      .miso_out(miso_out),
      .miso_oe(miso_oe),
      .irq(irq),
      .irq_status_main(irq_status_main),
      .tx_ctrl(tx_ctrl),
      .core(core),
      .fifo_wdata(fifo_wdata),
      .fifo_wvalid(fifo_wvalid),
      .tx_length(tx_length)
   );
   rhs_host_model u_rhs_host_model
   (
      .clk_sys(clk_sys),
      .miso_out(miso_out),
      .miso_oe(miso_oe),
      .sclk(sclk),
      .mosi(mosi),
      .sel_n(sel_n),
      .rx_byte(rx_byte),
      .rx_driven(rx_driven)
   );
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Pulse counters; the ceiling cuts a hung run short
   always @(negedge clk_sys)
   begin
      cyc++;
      if (tx_ctrl.tx_start === 1'b1)
         n_tx++;
      if (tx_ctrl.query_start === 1'b1)
         n_query++;
      if (core.adc_start === 1'b1)
         n_adc++;
      if (fifo_wvalid === 1'b1)
         n_fifo++;
      if (cyc == 40000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Whole frame of bytes; what came back lands in got
   task automatic send(input logic [7:0] q [$]);
      u_rhs_host_model.frame(1'b1);
      foreach (q[i])
      begin
         u_rhs_host_model.xfer(q[i], 8);
         got[i] = rx_byte;
      end
      u_rhs_host_model.frame(1'b0);
   endtask : send
   task automatic clr();
      irq_status_clear = 1'b1;
      @(negedge clk_sys);
      irq_status_clear = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("irq_clear", 16'(irq), 16'h0000);
   endtask : clr
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      irq_status_clear = 1'b0;
      tx_done = 1'b0;
      reset = 1'b1;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      chk("rst_irq", 16'(irq), 16'h0000);
      chk("rst_oe", 16'(miso_oe), 16'h0000);
      chk("rst_len", tx_length, 16'h0000);
      chk("rst_aux", 16'(core.synth_aux), 16'h0000);
      repeat (4) @(negedge clk_sys);
      send('{8'h00, 8'ha5});
      send('{8'h40, 8'h00});
      chk("rd_cfg", 16'(got[1]), 16'h00a5);
      send('{8'h38, 8'hff});
      send('{8'h78, 8'h00});
      chk("rd_status", 16'(got[1]), 16'h0000);
      send('{8'h20, 8'hff});
      send('{8'h60, 8'h00});
      chk("rd_unmapped", 16'(got[1]), 16'h0000);
      // Byte cut short by deselect must leave the register alone
      u_rhs_host_model.frame(1'b1);
      u_rhs_host_model.xfer(8'h00, 8);
      u_rhs_host_model.xfer(8'h3c, 5);
      u_rhs_host_model.frame(1'b0);
      send('{8'h40, 8'h00});
      chk("partial", 16'(got[1]), 16'h00a5);
      send('{8'h90, 8'h3d, 8'h00, 8'h30, 8'haa, 8'hbb});
      chk("tx_len", tx_length, 16'h0030);
      chk("tx_start", 16'(n_tx), 16'h0001);
      chk("fifo_n", 16'(n_fifo), 16'h0002);
      chk("fifo_data", 16'(fifo_wdata), 16'h00bb);
      chk("crc_on", 16'(tx_ctrl.tx_append_crc), 16'h0001);
      chk("irq_tx", 16'(irq), 16'h0001);
      clr();
      send('{8'h7d, 8'h00, 8'h00});
      chk("burst0", 16'(got[1]), 16'h0000);
      chk("burst1", 16'(got[2]), 16'h0030);
      chk("oe_read", 16'(rx_driven), 16'h0001);
      chk("oe_idle", 16'(miso_oe), 16'h0000);
      send('{8'h91, 8'h3f, 8'h11});
      chk("hdr", 16'(tx_ctrl.rx_expect_header), 16'h0001);
      chk("tx_start2", 16'(n_tx), 16'h0002);
      clr();
      send('{8'h92});
      chk("crc_off", 16'(tx_ctrl.tx_append_crc), 16'h0000);
      clr();
      send('{8'h98, 8'h3f, 8'h01, 8'h02});
      chk("query", 16'(n_query), 16'h0001);
      clr();
      send('{8'h9e});
      chk("unk_irq", 16'(irq), 16'h0000);
      chk("unk_flag", 16'(irq_status_main), 16'h0000);
      foreach (cmd_rows[k])
      begin
         send('{cmd_rows[k].code});
         chk("irq_cmd", 16'(irq), 16'(!cmd_rows[k].long_run));
         chk("busy", 16'(core.long_busy), 16'(cmd_rows[k].long_run));
         chk("aux", 16'(core.synth_aux), 16'(cmd_rows[k].aux));
         chk("blocked", 16'(core.rx_blocked), 16'(cmd_rows[k].blocked));
         repeat (cmd_rows[k].long_run ? `RHS_LONG_CMD_CYC + 20 : 0) @(negedge clk_sys);
         chk("done_flag", 16'(irq_status_main), 16'h0080);
         clr();
      end
      chk("adc", 16'(n_adc), 16'h0001);
      tx_done = 1'b1;
      @(negedge clk_sys);
      tx_done = 1'b0;
      repeat (`RHS_RX_WAIT_CYC - 10) @(negedge clk_sys);
      chk("blk_wait", 16'(core.rx_blocked), 16'h0001);
      repeat (20) @(negedge clk_sys);
      chk("blk_end", 16'(core.rx_blocked), 16'h0000);
      send('{8'h83});
      chk("init_len", tx_length, 16'h0000);
      send('{8'h40, 8'h00});
      chk("init_cfg", 16'(got[1]), 16'h0000);
      tally_and_finish();
   end
endmodule : test_reader_host_spi_command_port
`default_nettype wire
